/* File: dnconv_byte_sync.sv */
`timescale 1ns/1ns
`default_nettype none
// two-flop synchroniser for the byte link strobe
module dnconv_byte_sync (
   input  wire logic clk_sys,
   input  wire logic sys_rst,
   input  wire logic async_in,
   output logic      sync_out
);
   logic meta_q;

   // --------------------------------------------------
   // two stages
   // --------------------------------------------------
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         meta_q   <= 1'b0;
         sync_out <= 1'b0;
      end else begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule // dnconv_byte_sync
`default_nettype wire

/* File: dnconv_cfg_chk.sv */
`timescale 1ns/1ns
`default_nettype none
// ------------------
// write link checks
// ------------------
module dnconv_cfg_chk (
   input wire logic        clk_sys,
   input wire logic        sys_rst,
   input wire logic        reply_valid,
   input wire logic [7:0]  reply_byte,
   input wire logic        link_stalled,
   input wire logic        reprogram_current,
   input wire logic        restore_defaults,
   input wire logic        activity_led,
   input wire logic [9:0]  routing,
   input wire logic [47:0] freq_plan_word,
   input wire logic        freq_plan_load
);
   import dnconv_cfg_pkg::*;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   // reply pulses once, in the same cycle the setting lands
   sequence s_reply_after;
      reply_valid ##1 !reply_valid;
   endsequence
   reply_value_a: assert property (reply_valid |-> reply_byte == REPLY_BYTE)
      else $error("reply byte wrong");
   reply_pulse_a: assert property (reply_valid |=> !reply_valid)
      else $error("reply longer than one cycle");
   reinit_excl_a: assert property (!(reprogram_current && restore_defaults))
      else $error("both reinit pulses");
   reinit_reply_a: assert property ((reprogram_current || restore_defaults) |-> reply_valid)
      else $error("reinit pulse without reply");
   led_update_a: assert property ($changed(activity_led) |-> s_reply_after)
      else $error("indicator change without reply");
   route_update_a: assert property ($changed(routing) |-> s_reply_after)
      else $error("routing change without reply");
   plan_update_a: assert property ($changed(freq_plan_word) |-> freq_plan_load && reply_valid)
      else $error("plan word change without load");
   stall_quiet_a: assert property (link_stalled && $past(link_stalled) |-> !reply_valid)
      else $error("reply while stalled");
endmodule // dnconv_cfg_chk
`default_nettype wire

/* File: dnconv_cfg_pkg.sv */
package dnconv_cfg_pkg;

   // register addresses
   localparam logic [7:0] ADDR_STATE_REINIT  = 8'h01;
   localparam logic [7:0] ADDR_ACTIVITY      = 8'h02;
   localparam logic [7:0] ADDR_SIG_ROUTING   = 8'h16;
   localparam logic [7:0] ADDR_AUTO_GAIN     = 8'h17;
   localparam logic [7:0] ADDR_DEFAULT_SAVE  = 8'h18;
   localparam logic [7:0] ADDR_POWER_DOWN    = 8'h19;
   localparam logic [7:0] ADDR_REF_CLOCK     = 8'h1a;
   localparam logic [7:0] ADDR_REF_TRIM      = 8'h1b;
   localparam logic [7:0] ADDR_OSC_ROUTE     = 8'h1c;
   localparam logic [7:0] ADDR_SYNTH_CAL     = 8'h1d;
   localparam logic [7:0] ADDR_NVM_WRITE     = 8'h1e;
   localparam logic [7:0] ADDR_FREQ_PLAN     = 8'h1f;

   // data byte counts
   localparam logic [2:0] LEN_1 = 3'h1;
   localparam logic [2:0] LEN_3 = 3'h3;
   localparam logic [2:0] LEN_5 = 3'h5;
   localparam logic [2:0] LEN_7 = 3'h7;

   // reset values
   localparam logic [7:0]  RST_BYTE   = 8'h00;
   localparam logic [9:0]  RST_ROUTE  = 10'h000;
   localparam logic [55:0] RST_SHIFT  = 56'h0;
   localparam logic [2:0]  RST_COUNT  = 3'h0;

   // reply byte returned after each complete write
   localparam logic [7:0] REPLY_BYTE = 8'h00;

   // field positions
   localparam int ROUTE_W      = 10;
   localparam int AGAIN_W      = 40;
   localparam int TRIM_W       = 14;
   localparam int NVM_W        = 24;
   localparam int FREQ_W       = 48;
   localparam int PSEL_LSB     = 48;
   localparam int PSEL_W       = 4;
   localparam int SHIFT_W      = 56;

   typedef enum logic [2:0] {
      ST_ADDR  = 3'b001,
      ST_DATA  = 3'b010,
      ST_STALL = 3'b100
   } link_state_t;

endpackage

/* File: downconverter_config_regs.sv */
`timescale 1ns/1ns
`default_nettype none
module downconverter_config_regs (
   input  wire logic             clk_sys,
   input  wire logic             sys_rst,
   input  wire logic [7:0]       link_byte,
   input  wire logic             link_toggle,
   input  wire logic             link_resync,
   output logic                  reply_valid,
   output logic [7:0]            reply_byte,
   output logic                  link_stalled,
   output logic                  reprogram_current,
   output logic                  restore_defaults,
   output logic                  activity_led,
   output logic [9:0]            routing,
   output logic [39:0]           auto_gain,
   output logic                  default_save,
   output logic [7:0]            power_down,
   output logic [7:0]            ref_clock,
   output logic [13:0]           ref_trim,
   output logic                  osc_external,
   output logic                  synth_calibrate,
   output logic                  nvm_write,
   output logic [23:0]           nvm_word,
   output logic [47:0]           freq_plan_word,
   output logic [3:0]            plan_parameter_selector,
   output logic                  freq_plan_load
);
   import dnconv_cfg_pkg::*;

   // ----------------------------------------------------
   // link input capture
   // ----------------------------------------------------
   logic        tog_s;
   logic        tog_prev_q;
   logic        rsy_s;
   logic [7:0]  byte_m_q;
   logic [7:0]  byte_s_q;
   logic        byte_in;

   dnconv_byte_sync u_tog (
      .clk_sys  (clk_sys),
      .sys_rst  (sys_rst),
      .async_in (link_toggle),
      .sync_out (tog_s)
   );

   dnconv_byte_sync u_rsy (
      .clk_sys  (clk_sys),
      .sys_rst  (sys_rst),
      .async_in (link_resync),
      .sync_out (rsy_s)
   );

   // byte held stable by host around toggle; double-registered
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         byte_m_q   <= RST_BYTE;
         byte_s_q   <= RST_BYTE;
         tog_prev_q <= 1'b0;
      end else begin
         byte_m_q   <= link_byte;
         byte_s_q   <= byte_m_q;
         tog_prev_q <= tog_s;
      end
   end

   assign byte_in = tog_s ^ tog_prev_q;

   // ----------------------------------------------------
   // frame decode
   // ----------------------------------------------------
   link_state_t state_q;
   logic [7:0]  addr_q;
   logic [2:0]  need_q;
   logic [2:0]  got_q;
   logic [55:0] shift_q;
   logic [2:0]  len;
   logic        frame_done;

   // one byte map for every link
   always_comb begin
      unique case (link_byte_addr_sel(state_q, byte_s_q, addr_q))
         ADDR_STATE_REINIT, ADDR_ACTIVITY, ADDR_DEFAULT_SAVE, ADDR_POWER_DOWN,
         ADDR_REF_CLOCK, ADDR_OSC_ROUTE, ADDR_SYNTH_CAL: len = LEN_1;
         ADDR_SIG_ROUTING, ADDR_REF_TRIM, ADDR_NVM_WRITE: len = LEN_3;
         ADDR_AUTO_GAIN: len = LEN_5;
         ADDR_FREQ_PLAN: len = LEN_7;
         default: len = RST_COUNT;
      endcase
   end

   function automatic logic [7:0] link_byte_addr_sel(input link_state_t s,
                                                      input logic [7:0] b,
                                                      input logic [7:0] a);
      link_byte_addr_sel = (s == ST_ADDR) ? b : a;
   endfunction

   assign frame_done = (state_q == ST_DATA) && byte_in && (got_q + 3'h1 == need_q);

   // address byte then exact data count; unknown address stalls
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         state_q <= ST_ADDR;
         addr_q  <= RST_BYTE;
         need_q  <= RST_COUNT;
         got_q   <= RST_COUNT;
      end else begin
         unique case (state_q)
            ST_ADDR: begin
               if (byte_in) begin
                  addr_q <= byte_s_q;
                  need_q <= len;
                  got_q  <= RST_COUNT;
                  state_q <= (len == RST_COUNT) ? ST_STALL : ST_DATA;
               end
            end
            ST_DATA: begin
               if (byte_in) begin
                  got_q <= got_q + 3'h1;
                  if (frame_done) begin
                     state_q <= ST_ADDR;
                  end
               end
            end
            ST_STALL: begin
               if (rsy_s) begin
                  state_q <= ST_ADDR;
               end
            end
            default: state_q <= ST_ADDR;
         endcase
      end
   end

   // least significant byte first into shifter
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         shift_q <= RST_SHIFT;
      end else if (state_q == ST_ADDR && byte_in) begin
         shift_q <= RST_SHIFT;
      end else if (state_q == ST_DATA && byte_in) begin
         shift_q[got_q*8 +: 8] <= byte_s_q;
      end
   end

   // full frame with last byte merged
   logic [55:0] frame;
   always_comb begin
      frame = shift_q;
      frame[got_q*8 +: 8] = byte_s_q;
   end

   // ----------------------------------------------------
   // stored settings usable without prior reinit
   // ----------------------------------------------------
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         activity_led            <= 1'b0;
         routing                 <= RST_ROUTE;
         auto_gain               <= '0;
         power_down              <= RST_BYTE;
         ref_clock               <= RST_BYTE;
         ref_trim                <= '0;
         osc_external            <= 1'b0;
         nvm_word                <= '0;
         freq_plan_word          <= '0;
         plan_parameter_selector <= '0;
      end else if (frame_done) begin
         unique case (addr_q)
            ADDR_ACTIVITY:    activity_led <= frame[0];
            ADDR_SIG_ROUTING: routing <= frame[ROUTE_W-1:0];
            ADDR_AUTO_GAIN:   auto_gain <= frame[AGAIN_W-1:0];
            ADDR_POWER_DOWN:  power_down <= frame[7:0];
            ADDR_REF_CLOCK:   ref_clock <= frame[7:0];
            ADDR_REF_TRIM:    ref_trim <= frame[TRIM_W-1:0];
            ADDR_OSC_ROUTE:   osc_external <= frame[0];
            ADDR_NVM_WRITE:   nvm_word <= frame[NVM_W-1:0];
            ADDR_FREQ_PLAN: begin
               freq_plan_word          <= frame[FREQ_W-1:0];
               plan_parameter_selector <= frame[PSEL_LSB +: PSEL_W];
            end
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------
   // one-cycle command pulses
   // ----------------------------------------------------
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         reprogram_current <= 1'b0;
         restore_defaults  <= 1'b0;
         default_save      <= 1'b0;
         synth_calibrate   <= 1'b0;
         nvm_write         <= 1'b0;
         freq_plan_load    <= 1'b0;
      end else begin
         reprogram_current <= frame_done && addr_q == ADDR_STATE_REINIT && !frame[0];
         restore_defaults  <= frame_done && addr_q == ADDR_STATE_REINIT && frame[0];
         default_save      <= frame_done && addr_q == ADDR_DEFAULT_SAVE;
         synth_calibrate   <= frame_done && addr_q == ADDR_SYNTH_CAL;
         nvm_write         <= frame_done && addr_q == ADDR_NVM_WRITE;
         freq_plan_load    <= frame_done && addr_q == ADDR_FREQ_PLAN;
      end
   end

   // ----------------------------------------------------
   // reply byte and status
   // ----------------------------------------------------
   // one reply per write; reply never echoes settings
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         reply_valid  <= 1'b0;
         reply_byte   <= RST_BYTE;
         link_stalled <= 1'b0;
      end else begin
         reply_valid  <= frame_done;
         reply_byte   <= REPLY_BYTE;
         link_stalled <= (state_q == ST_STALL);
      end
   end
endmodule // downconverter_config_regs
`default_nettype wire

/* File: downconverter_config_regs_tb.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin failures++; \
   $display("[ERR] %s exp %h got %h", nm, ex, got); end end
module downconverter_config_regs_tb;
   import dnconv_cfg_pkg::*;
   logic        clk_sys, sys_rst, link_toggle, link_resync, reply_valid, link_stalled;
   logic        reprogram_current, restore_defaults, activity_led, freq_plan_load;
   logic [7:0]  link_byte, reply_byte, power_down;
   logic [9:0]  routing;
   logic [47:0] freq_plan_word;
   logic [3:0]  plan_parameter_selector;
   logic        default_save, synth_calibrate, nvm_write, osc_external;
   logic [7:0]  ref_clock;
   logic [13:0] ref_trim;
   logic [23:0] nvm_word;
   logic [39:0] auto_gain;
   int          failures, check_count, n_rep, n_rc, n_rd, n_pl, n_ds, n_sc, n_nw;
   host_link_model u_host_link_model (.clk_sys, .link_byte, .link_toggle);
   downconverter_config_regs u_downconverter_config_regs (.clk_sys, .sys_rst, .link_byte,
      .link_toggle, .link_resync, .reply_valid, .reply_byte, .link_stalled, .reprogram_current,
      .restore_defaults, .activity_led, .routing, .auto_gain, .default_save, .power_down,
      .ref_clock, .ref_trim, .osc_external, .synth_calibrate, .nvm_write,
      .nvm_word, .freq_plan_word, .plan_parameter_selector, .freq_plan_load);
   // clock and pulse counters
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      n_rep <= n_rep + (reply_valid === 1'b1);
      n_rc <= n_rc + (reprogram_current === 1'b1);
      n_rd <= n_rd + (restore_defaults === 1'b1);
      n_pl <= n_pl + (freq_plan_load === 1'b1);
      n_ds <= n_ds + (default_save === 1'b1);
      n_sc <= n_sc + (synth_calibrate === 1'b1);
      n_nw <= n_nw + (nvm_write === 1'b1);
   end
   task automatic print_verdict;
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // address byte, then data low byte first
   task automatic wr(input logic [7:0] a, input int n, input logic [55:0] d);
      int r;
      r = n_rep;
      u_host_link_model.send(a);
      for (int i = 0; i < n; i++) u_host_link_model.send(d[8*i +: 8]);
      repeat (8) @(posedge clk_sys);
      `CHK("reply count", 1, n_rep - r)
      `CHK("reply_byte", REPLY_BYTE, reply_byte)
   endtask
   task automatic t_reinit;
      int c;
      int d;
      c = n_rc;
      d = n_rd;
      wr(ADDR_STATE_REINIT, 1, 56'h00);
      `CHK("reprogram", 1, n_rc - c)
      `CHK("restore", 0, n_rd - d)
      wr(ADDR_STATE_REINIT, 1, 56'h01);
      `CHK("restore", 1, n_rd - d)
      `CHK("reprogram", 1, n_rc - c)
      $display("test reinit done");
   endtask
   task automatic t_activity;
      wr(ADDR_ACTIVITY, 1, 56'h01);
      `CHK("activity_led", 1'b1, activity_led)
      wr(ADDR_ACTIVITY, 1, 56'h00);
      `CHK("activity_led", 1'b0, activity_led)
      $display("test activity done");
   endtask
   task automatic t_route;
      wr(ADDR_SIG_ROUTING, 3, 56'h0003a5);
      `CHK("routing", 10'h3a5, routing)
      wr(ADDR_POWER_DOWN, 1, 56'h0f);
      `CHK("power_down", 8'h0f, power_down)
      $display("test routing done");
   endtask
   task automatic t_plan;
      int p;
      p = n_pl;
      wr(ADDR_FREQ_PLAN, 7, 56'h0b123456789abc);
      `CHK("freq_plan_word", 48'h123456789abc, freq_plan_word)
      `CHK("plan_parameter_selector", 4'hb, plan_parameter_selector)
      `CHK("load count", 1, n_pl - p)
      $display("test plan done");
   endtask
   task automatic t_misc;
      int s;
      int k;
      int w;
      s = n_ds;
      k = n_sc;
      w = n_nw;
      wr(ADDR_AUTO_GAIN, 5, 56'h001e140a03);
      `CHK("auto_gain", 40'h001e140a03, auto_gain)
      wr(ADDR_REF_CLOCK, 1, 56'h05);
      `CHK("ref_clock", 8'h05, ref_clock)
      wr(ADDR_REF_TRIM, 3, 56'h002abc);
      `CHK("ref_trim", 14'h2abc, ref_trim)
      wr(ADDR_OSC_ROUTE, 1, 56'h01);
      `CHK("osc_external", 1'b1, osc_external)
      wr(ADDR_NVM_WRITE, 3, 56'h12345a);
      `CHK("nvm_word", 24'h12345a, nvm_word)
      `CHK("nvm_write", 1, n_nw - w)
      wr(ADDR_DEFAULT_SAVE, 1, 56'h00);
      `CHK("default_save", 1, n_ds - s)
      wr(ADDR_SYNTH_CAL, 1, 56'h00);
      `CHK("synth_calibrate", 1, n_sc - k)
      $display("test misc done");
   endtask
   task automatic t_stall;
      int r;
      r = n_rep;
      u_host_link_model.send(8'h05);
      u_host_link_model.send(ADDR_ACTIVITY);
      u_host_link_model.send(8'h01);
      repeat (6) @(posedge clk_sys);
      `CHK("link_stalled", 1'b1, link_stalled)
      `CHK("stalled replies", 0, n_rep - r)
      `CHK("activity_led", 1'b0, activity_led)
      link_resync <= 1'b1;
      repeat (6) @(posedge clk_sys);
      link_resync <= 1'b0;
      repeat (6) @(posedge clk_sys);
      `CHK("link_stalled", 1'b0, link_stalled)
      wr(ADDR_ACTIVITY, 1, 56'h01);
      `CHK("activity_led", 1'b1, activity_led)
      wr(ADDR_ACTIVITY, 1, 56'h00);
      $display("test stall done");
   endtask
   // watchdog
   initial begin
      repeat (5000) @(posedge clk_sys);
      failures++;
      print_verdict();
   end
   // main sequence
   initial begin
      sys_rst = 1'b1;
      link_resync = 1'b0;
      repeat (12) @(posedge clk_sys);
      sys_rst <= 1'b0;
      t_reinit();
      t_activity();
      t_route();
      t_plan();
      t_misc();
      t_stall();
      print_verdict();
   end
endmodule // downconverter_config_regs_tb
bind downconverter_config_regs dnconv_cfg_chk u_dnconv_cfg_chk (.clk_sys(clk_sys),
   .sys_rst(sys_rst), .reply_valid(reply_valid), .reply_byte(reply_byte),
   .link_stalled(link_stalled), .reprogram_current(reprogram_current),
   .restore_defaults(restore_defaults), .activity_led(activity_led), .routing(routing),
   .freq_plan_word(freq_plan_word), .freq_plan_load(freq_plan_load));
`default_nettype wire

/* File: host_link_model.sv */
`timescale 1ns/1ns
`default_nettype none
// -----------------
// host byte sender
// -----------------
module host_link_model (
   input  wire logic       clk_sys,
   output var  logic [7:0] link_byte,
   output var  logic       link_toggle
);
   // idle link at time zero
   initial begin
      link_byte = 8'h00;
      link_toggle = 1'b0;
   end
   task automatic send(input logic [7:0] b);
      @(posedge clk_sys) link_byte <= b;
      @(posedge clk_sys) link_toggle <= ~link_toggle;
      repeat (5) @(posedge clk_sys);
      link_byte <= ~b; // stale value no longer shown
   endtask
endmodule // host_link_model
`default_nettype wire
